// *** rtl/asc_pkg.sv ***
// Purpose: constants and types of the converter sequence control
// Assumes: mclk is the E clock, 125 MHz
// Notes: register offsets are on the plain register port
// Summary of operation
// - sequence starts one cycle after control write
// - done flag set after fourth conversion
// - four readable 8-bit result slots
// - slot updates never collide with reads
// - clock select: E clock or RC tick
// - option bit 7 powers the converter
// - protected option bit 4: write-once in 64 cycles, any time in special mode
// - stop exit delay 4000 cycles or four
// - low reference 00, high reference ff
// - sixteen channel codes to the multiplexer
// - single channel, no scan: four, halt
// - single channel scan: slots cycle round
// - group, no scan: four channels, halt
// - group scan: keep cycling the group
// - stop or wait suspends, resample on resume
// - control bit 7 read-only, bit 6 zero
// - control write abandons running sequence
// - control write clears done, starts sequence
// - scan: done after first sequence, keep updating
// - group bit clear: one channel from bits 3:0
// - group: high two bits select the group
// - result slots ignore writes
// - eight comparisons, msb first, then transfer
package asc_pkg;
    localparam int ADDR_W = 3;
    localparam logic [2:0] OFS_CTL = 3'h0;
    localparam logic [2:0] OFS_RES1 = 3'h1;
    localparam logic [2:0] OFS_RES4 = 3'h4;
    localparam logic [2:0] OFS_OPT = 3'h5;
    localparam int CTL_DONE_BIT = 7;
    localparam int CTL_SCAN_BIT = 5;
    localparam int CTL_GROUP_MODE_BIT = 4;
    localparam int OPT_PWR_BIT = 7;
    localparam int OPT_CONVERSION_CLOCK_SELECT_BIT = 6;
    localparam int OPT_DLY_BIT = 4;
    localparam logic [7:0] CTL_RST = 8'h00;
    localparam logic [7:0] OPT_RST = 8'h10;
    localparam int PROT_WINDOW = 64;
    localparam int CONV_CYCLES = 32;
    localparam int SAMPLE_CYCLES = 12;
    localparam int STEP_CYCLES = 2;
    localparam int SAR_BITS = 8;
    localparam int SEQ_LEN = 4;
    localparam logic [4:0] PH_SAMPLE_END = 5'(SAMPLE_CYCLES - 1);
    localparam logic [4:0] PH_CMP_END =
        5'(SAMPLE_CYCLES + SAR_BITS * STEP_CYCLES - 1);
    localparam logic [4:0] PH_LAST = 5'(CONV_CYCLES - 1);
    localparam logic [1:0] IDX_LAST = 2'(SEQ_LEN - 1);
    localparam logic [7:0] SAR_MSB = 8'h80;
    localparam int STOP_DLY_LONG = 4000;
    localparam int STOP_DLY_SHORT = 4;
    typedef enum logic [1:0] {ST_IDLE, ST_SAMPLE, ST_CONVERT} asc_state_t;
endpackage

// *** rtl/asc_sar_if.sv ***
// Purpose: carrier between sequencer and approximation engine
// Assumes: one clock domain
// Notes: comparator level travels with the step strobe
`timescale 1ns/1ps
interface asc_sar_if;
    logic start;
    logic step;
    logic comp;
    logic [7:0] trial;
    logic [7:0] result;
    logic done;
    modport seq (output start, output step, output comp,
        input trial, input result, input done);
    modport sar (input start, input step, input comp,
        output trial, output result, output done);
endinterface

// *** rtl/asc_sar.sv ***
// Purpose: successive approximation register, msb first
// Assumes: comp high means input at or above trial code
// Notes: result holds until the next completed conversion
`timescale 1ns/1ps
module asc_sar
    import asc_pkg::*;
(
    input wire logic mclk,
    input wire logic reset_n,
    asc_sar_if.sar sif
);
    logic [7:0] trial_ff;
    logic [7:0] mask_ff;
    logic [7:0] result_ff;
    logic done_ff;
    logic [7:0] nxt_trial;

    always_comb begin
        nxt_trial = sif.comp ? trial_ff : (trial_ff & ~mask_ff);
        nxt_trial = nxt_trial | (mask_ff >> 1);
    end

    // ---------------------------------------------
    // approximation steps
    // ---------------------------------------------
    always_ff @(posedge mclk) begin
        if (!reset_n) begin
            trial_ff <= 8'h00;
            mask_ff <= 8'h00;
            result_ff <= 8'h00;
            done_ff <= 1'b0;
        end else begin
            done_ff <= 1'b0;
            if (sif.start) begin
                trial_ff <= SAR_MSB;
                mask_ff <= SAR_MSB;
            end else if (sif.step && mask_ff != 8'h00) begin
                trial_ff <= nxt_trial;
                mask_ff <= mask_ff >> 1;
                if (mask_ff == 8'h01) begin
                    // full range 00..ff, no overflow bit
                    result_ff <= nxt_trial;
                    done_ff <= 1'b1;
                end
            end
        end
    end

    assign sif.trial = trial_ff;
    assign sif.result = result_ff;
    assign sif.done = done_ff;

    a_sar_msb_first: assert property (@(posedge mclk) disable iff
        (!reset_n) sif.start |=> trial_ff == SAR_MSB)
        else $error("trial does not start at msb");
endmodule

// *** rtl/asc_wake.sv ***
// Purpose: stop-exit hold-off counter
// Assumes: stop_mode is a level, high while stopped
// Notes: long count covers oscillator settling
`timescale 1ns/1ps
module asc_wake
    import asc_pkg::*;
(
    input wire logic mclk,
    input wire logic reset_n,
    input wire logic stop_mode,
    input wire logic delay_en,
    output logic ready
);
    logic [11:0] cnt_ff;
    logic busy_ff;

    always_ff @(posedge mclk) begin
        if (!reset_n) begin
            cnt_ff <= 12'h000;
            busy_ff <= 1'b0;
        end else if (stop_mode) begin
            busy_ff <= 1'b1;
            cnt_ff <= delay_en ? 12'(STOP_DLY_LONG - 1)
                               : 12'(STOP_DLY_SHORT - 1);
        end else if (busy_ff) begin
            if (cnt_ff == 12'h000) begin
                busy_ff <= 1'b0;
            end else begin
                cnt_ff <= cnt_ff - 12'h001;
            end
        end
    end

    assign ready = !busy_ff && !stop_mode;

    a_wake_short: assert property (@(posedge mclk) disable iff
        (!reset_n) $fell(stop_mode) && !delay_en
        |-> ##[1:5] ready)
        else $error("fast stop exit too slow");
endmodule

// *** rtl/asc_top.sv ***
// Purpose: control of a four-conversion sequenced 8-bit converter
// Assumes: register port strobes are one cycle, synchronous
// Notes: analog core supplies comp_above and rc_tick
`timescale 1ns/1ps
module asc_top
    import asc_pkg::*;
(
    input wire logic mclk,
    input wire logic reset_n,
    input wire logic [ADDR_W-1:0] reg_addr,
    input wire logic [7:0] reg_wdata,
    input wire logic reg_wr,
    input wire logic reg_rd,
    output logic [7:0] reg_rdata,
    input wire logic special_mode,
    input wire logic stop_mode,
    input wire logic wait_mode,
    input wire logic rc_tick,
    input wire logic comp_above,
    output logic [3:0] mux_channel,
    output logic sample_gate,
    output logic [7:0] dac_code,
    output logic converter_power_on,
    output logic conversion_clock_select,
    output logic stop_exit_ready
);
    default clocking cb @(posedge mclk); endclocking
    default disable iff (!reset_n);

    // ---------------------------------------------
    // declarations
    // ---------------------------------------------
    logic [7:0] ctl_ff;
    logic [7:0] opt_ff;
    logic done_ff;
    logic start_ff;
    logic [6:0] prot_cnt_ff;
    logic prot_wrote_ff;
    asc_state_t state_ff;
    asc_state_t nxt_state;
    logic [4:0] phase_ff;
    logic [4:0] nxt_phase;
    logic [1:0] idx_ff;
    logic [1:0] nxt_idx;
    logic [7:0] slot_ff [SEQ_LEN];
    logic [7:0] rdata_ff;
    logic ctl_wr;
    logic opt_wr;
    logic prot_open;
    logic tick;
    logic halt;
    logic wake_ready;
    logic conv_end;
    logic done_set;
    logic seq_last;
    logic sar_start;
    logic sar_step;
    logic scan;
    logic group_mode;

    asc_sar_if sif ();

    // ---------------------------------------------
    // decode
    // ---------------------------------------------
    assign ctl_wr = reg_wr && reg_addr == OFS_CTL;
    assign opt_wr = reg_wr && reg_addr == OFS_OPT;
    assign scan = ctl_ff[CTL_SCAN_BIT];
    assign group_mode = ctl_ff[CTL_GROUP_MODE_BIT];

    // ---------------------------------------------
    // option register
    // ---------------------------------------------
    // protected bit opens for a single write early after reset, and for any write in special mode
    assign prot_open = special_mode
        || (prot_cnt_ff < 7'(PROT_WINDOW) && !prot_wrote_ff);

    always_ff @(posedge mclk) begin
        if (!reset_n) begin
            prot_cnt_ff <= 7'h00;
        end else if (prot_cnt_ff < 7'(PROT_WINDOW)) begin
            prot_cnt_ff <= prot_cnt_ff + 7'h01;
        end
    end

    always_ff @(posedge mclk) begin
        if (!reset_n) begin
            prot_wrote_ff <= 1'b0;
        end else if (opt_wr && prot_open) begin
            prot_wrote_ff <= 1'b1;
        end
    end

    always_ff @(posedge mclk) begin
        if (!reset_n) begin
            opt_ff <= OPT_RST;
        end else if (opt_wr) begin
            opt_ff[OPT_PWR_BIT] <= reg_wdata[OPT_PWR_BIT];
            opt_ff[OPT_CONVERSION_CLOCK_SELECT_BIT] <= reg_wdata[OPT_CONVERSION_CLOCK_SELECT_BIT];
            if (prot_open) begin
                opt_ff[OPT_DLY_BIT] <= reg_wdata[OPT_DLY_BIT];
            end
        end
    end

    assign converter_power_on = opt_ff[OPT_PWR_BIT];
    assign conversion_clock_select = opt_ff[OPT_CONVERSION_CLOCK_SELECT_BIT];

    // ---------------------------------------------
    // control register
    // ---------------------------------------------
    // bit 7 lives in done_ff and bit 6 is not stored
    always_ff @(posedge mclk) begin
        if (!reset_n) begin
            ctl_ff <= CTL_RST;
        end else if (ctl_wr) begin
            ctl_ff <= {2'b00, reg_wdata[5:0]};
        end
    end

    // start follows the write by one cycle, with fresh settings
    always_ff @(posedge mclk) begin
        if (!reset_n) begin
            start_ff <= 1'b0;
        end else begin
            start_ff <= ctl_wr;
        end
    end

    // set wins over the clear of a write in the same cycle
    always_ff @(posedge mclk) begin
        if (!reset_n) begin
            done_ff <= 1'b0;
        end else if (done_set) begin
            done_ff <= 1'b1;
        end else if (ctl_wr) begin
            done_ff <= 1'b0;
        end
    end

    // ---------------------------------------------
    // timing source and suspension
    // ---------------------------------------------
    // rc tick is asynchronous to bus in silicon, adds noise
    assign tick = conversion_clock_select ? rc_tick : 1'b1;
    assign halt = stop_mode || wait_mode || !wake_ready
        || !converter_power_on;

    asc_wake u_wake (
        .mclk(mclk),
        .reset_n(reset_n),
        .stop_mode(stop_mode),
        .delay_en(opt_ff[OPT_DLY_BIT]),
        .ready(wake_ready)
    );

    assign stop_exit_ready = wake_ready;

    // ---------------------------------------------
    // sequencer
    // ---------------------------------------------
    assign conv_end = state_ff == ST_CONVERT && phase_ff == PH_LAST
        && tick && !halt && !start_ff;
    assign seq_last = idx_ff == IDX_LAST;
    assign done_set = conv_end && seq_last;

    always_comb begin
        nxt_state = state_ff;
        nxt_phase = phase_ff;
        nxt_idx = idx_ff;
        if (start_ff) begin
            nxt_state = ST_SAMPLE;
            nxt_phase = 5'h00;
            nxt_idx = 2'h0;
        end else if (halt && state_ff != ST_IDLE) begin
            nxt_state = ST_SAMPLE;
            nxt_phase = 5'h00;
        end else if (tick) begin
            case (state_ff)
                ST_IDLE: begin
                    nxt_state = ST_IDLE;
                end
                ST_SAMPLE: begin
                    nxt_phase = phase_ff + 5'h01;
                    if (phase_ff == PH_SAMPLE_END) begin
                        nxt_state = ST_CONVERT;
                    end
                end
                ST_CONVERT: begin
                    nxt_phase = phase_ff + 5'h01;
                    if (phase_ff == PH_LAST) begin
                        nxt_phase = 5'h00;
                        nxt_idx = idx_ff + 2'h1;
                        if (seq_last && !scan) begin
                            nxt_state = ST_IDLE;
                        end else begin
                            nxt_state = ST_SAMPLE;
                        end
                    end
                end
                default: begin
                    nxt_state = ST_IDLE;
                end
            endcase
        end
    end

    always_ff @(posedge mclk) begin
        if (!reset_n) begin
            state_ff <= ST_IDLE;
            phase_ff <= 5'h00;
            idx_ff <= 2'h0;
        end else begin
            state_ff <= nxt_state;
            phase_ff <= nxt_phase;
            idx_ff <= nxt_idx;
        end
    end

    // ---------------------------------------------
    // analog core drive
    // ---------------------------------------------
    // group mode drops the low select bits for the slot index
    assign mux_channel = group_mode ? {ctl_ff[3:2], idx_ff}
                              : ctl_ff[3:0];
    assign sample_gate = state_ff == ST_SAMPLE && !halt;

    assign sar_start = state_ff == ST_SAMPLE && phase_ff == PH_SAMPLE_END
        && tick && !halt && !start_ff;
    assign sar_step = state_ff == ST_CONVERT && tick && !halt
        && !start_ff && phase_ff > PH_SAMPLE_END
        && phase_ff <= PH_CMP_END && phase_ff[0];

    assign sif.start = sar_start;
    assign sif.step = sar_step;
    assign sif.comp = comp_above;
    assign dac_code = sif.trial;

    asc_sar u_sar (
        .mclk(mclk),
        .reset_n(reset_n),
        .sif(sif)
    );

    // ---------------------------------------------
    // result slots
    // ---------------------------------------------
    // a read samples the old value, so the update never collides
    always_ff @(posedge mclk) begin
        if (!reset_n) begin
            for (int i = 0; i < SEQ_LEN; i++) begin
                slot_ff[i] <= 8'h00;
            end
        end else if (conv_end) begin
            slot_ff[idx_ff] <= sif.result;
        end
    end

    // ---------------------------------------------
    // read port
    // ---------------------------------------------
    // slot writes fall through to nothing
    always_ff @(posedge mclk) begin
        if (!reset_n) begin
            rdata_ff <= 8'h00;
        end else if (reg_rd) begin
            case (reg_addr)
                OFS_CTL: rdata_ff <= {done_ff, 1'b0, ctl_ff[5:0]};
                OFS_OPT: rdata_ff <= opt_ff & 8'hd0;
                3'h1, 3'h2, 3'h3, 3'h4: begin
                    rdata_ff <= slot_ff[2'(reg_addr - OFS_RES1)];
                end
                default: rdata_ff <= 8'h00;
            endcase
        end else begin
            rdata_ff <= 8'h00;
        end
    end

    assign reg_rdata = rdata_ff;

    // ---------------------------------------------
    // checks
    // ---------------------------------------------
    sequence s_ctl_write;
        reg_wr && reg_addr == OFS_CTL;
    endsequence

    sequence s_fresh_start;
        state_ff == ST_SAMPLE && phase_ff == 5'h00 && idx_ff == 2'h0;
    endsequence

    // one undisturbed system clock of a running conversion
    sequence s_conv_quiet;
        !halt && !start_ff && !conversion_clock_select;
    endsequence

    a_start_after_write: assert property (
        s_ctl_write |-> ##2 s_fresh_start)
        else $error("sequence did not restart after write");

    a_done_cleared: assert property (
        ctl_wr && !done_set |=> !done_ff)
        else $error("done flag not cleared by write");

    a_done_after_four: assert property (
        conv_end && idx_ff == IDX_LAST |=> done_ff)
        else $error("done flag missing after fourth");

    a_bit_six_zero: assert property (
        reg_rd && reg_addr == OFS_CTL |=> reg_rdata[6] == 1'b0)
        else $error("control bit 6 read as one");

    a_single_halts: assert property (
        done_set && !scan && !ctl_wr |=> state_ff == ST_IDLE)
        else $error("single sequence did not halt");

    a_scan_wraps: assert property (
        done_set && scan && !ctl_wr |=> state_ff == ST_SAMPLE
        && idx_ff == 2'h0)
        else $error("scan did not wrap to first slot");

    a_halt_resample: assert property (
        halt && state_ff != ST_IDLE && !start_ff
        |=> state_ff == ST_SAMPLE && phase_ff == 5'h00)
        else $error("suspended conversion not resampled");

    a_slot_readonly: assert property (
        reg_wr && reg_addr == OFS_RES1 && !conv_end
        |=> $stable(slot_ff[0]))
        else $error("result slot changed by write");

    a_prot_once: assert property (
        opt_wr && !prot_open |=> $stable(opt_ff[OPT_DLY_BIT]))
        else $error("protected option bit rewritten");

    // a halt or restart mid-conversion legally moves the phase back
    a_conv_length: assert property (
        sar_start && !conversion_clock_select ##1 s_conv_quiet [*8]
        ##1 s_conv_quiet [*8] ##1 s_conv_quiet [*3]
        |=> state_ff == ST_CONVERT && phase_ff == PH_LAST)
        else $error("conversion timing off");

    a_sar_done_time: assert property (
        sif.done |-> state_ff == ST_CONVERT
        && phase_ff == PH_CMP_END + 5'h01)
        else $error("approximation ended off its step");
endmodule

// *** tb/asc_core_model.sv ***
// Purpose: analog core and input multiplexer model
// Assumes: comparator settles within one clock
// Notes: rc oscillator ticks every third clock, free running
`timescale 1ns/1ps
module asc_core_model (
    input wire logic mclk,
    input wire logic [3:0] mux_channel,
    input wire logic [7:0] dac_code,
    output logic comp_above,
    output logic rc_tick
);
    // ----------------------------------------
    // channel levels and comparator
    // ----------------------------------------
    logic [7:0] level [16];
    logic [1:0] div_ff = 2'h0;
    initial begin
        for (int i = 0; i < 12; i++) begin
            level[i] = 8'(8'h11 * (i + 1));
        end
        level[12] = 8'hff;
        level[13] = 8'h00;
        level[14] = 8'h80;
        level[15] = 8'h5a;
    end
    // ideal comparator, so a full search lands on the level exactly
    assign comp_above = level[mux_channel] >= dac_code;
    always @(posedge mclk) begin
        div_ff <= (div_ff == 2'h2) ? 2'h0 : div_ff + 2'h1;
    end
    assign rc_tick = div_ff == 2'h2;
endmodule

// *** tb/tb.sv ***
// Purpose: self-checking bench for the sequenced converter control
// Assumes: core model answers within a clock
// Notes: every wait is bounded, a spent bound counts as a mismatch
`timescale 1ns/1ps
module tb;
    import asc_pkg::*;
    // ----------------------------------------
    // stimulus and wiring
    // ----------------------------------------
    typedef struct {
        logic [7:0] ctl;
        logic [31:0] res;
    } asc_row_t;
    logic mclk = 1'h0;
    logic reset_n = 1'h0;
    logic [ADDR_W-1:0] reg_addr = 3'h0;
    logic [7:0] reg_wdata = 8'h00;
    logic reg_wr = 1'h0;
    logic reg_rd = 1'h0;
    logic special_mode = 1'h0;
    logic stop_mode = 1'h0;
    logic wait_mode = 1'h0;
    logic rc_tick, comp_above, sample_gate, converter_power_on;
    logic conversion_clock_select, stop_exit_ready;
    logic [7:0] reg_rdata, dac_code, d;
    logic [3:0] mux_channel;
    int num_errors = 0;
    int total_checks = 0;
    int cyc = 0;
    int t0, lat;
    // slot one in the low byte
    asc_row_t rows [7] = '{
        '{8'h03, 32'h44444444},
        '{8'h0d, 32'h00000000},
        '{8'h0c, 32'hffffffff},
        '{8'h1f, 32'h5a8000ff},
        '{8'h15, 32'h88776655},
        '{8'h34, 32'h88776655},
        '{8'h1b, 32'hccbbaa99}};
    always #4 mclk = ~mclk;
    always @(posedge mclk) cyc <= cyc + 1;
    asc_top dut (.mclk(mclk), .reset_n(reset_n), .reg_addr(reg_addr),
        .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd),
        .reg_rdata(reg_rdata), .special_mode(special_mode),
        .stop_mode(stop_mode), .wait_mode(wait_mode), .rc_tick(rc_tick),
        .comp_above(comp_above), .mux_channel(mux_channel),
        .sample_gate(sample_gate), .dac_code(dac_code),
        .converter_power_on(converter_power_on),
        .conversion_clock_select(conversion_clock_select),
        .stop_exit_ready(stop_exit_ready));
    asc_core_model core (.mclk(mclk), .mux_channel(mux_channel),
        .dac_code(dac_code), .comp_above(comp_above), .rc_tick(rc_tick));
    // ----------------------------------------
    // bus, compare and wait tasks
    // ----------------------------------------
    task automatic conclude();
        $display("checks %0d errors %0d", total_checks, num_errors);
        if (num_errors == 0 && total_checks > 0) begin
            $display("NO MISMATCHES");
        end else begin
            $display("MISMATCHES SEEN");
        end
        $finish;
    endtask
    task automatic chk8(input string n, input logic [7:0] e, g);
        total_checks++;
        if (g !== e) begin
            $display("BAD %s exp %h got %h", n, e, g);
            num_errors++;
        end
    endtask
    task automatic chk_rng(input string n, input int lo, hi, g);
        total_checks++;
        if (g < lo || g > hi) begin
            $display("BAD %s exp %0d..%0d got %0d", n, lo, hi, g);
            num_errors++;
        end
    endtask
    task automatic wr(input logic [2:0] a, input logic [7:0] v);
        @(posedge mclk);
        reg_addr <= a;
        reg_wdata <= v;
        reg_wr <= 1'h1;
        @(posedge mclk);
        reg_wr <= 1'h0;
    endtask
    task automatic rd(input logic [2:0] a, output logic [7:0] v);
        @(posedge mclk);
        reg_addr <= a;
        reg_rd <= 1'h1;
        @(posedge mclk);
        reg_rd <= 1'h0;
        #1 v = reg_rdata;
    endtask
    task automatic rc(input logic [2:0] a, input logic [7:0] e,
        input string n);
        rd(a, d);
        chk8(n, e, d);
    endtask
    task automatic start(input logic [7:0] v);
        wr(OFS_CTL, v);
        t0 = cyc;
    endtask
    // polling costs two clocks, so latencies carry that slack
    task automatic seq_done();
        for (int i = 0; i < 600; i++) begin
            rd(OFS_CTL, d);
            if (d[CTL_DONE_BIT] === 1'h1) begin
                lat = cyc - t0;
                return;
            end
        end
        $display("BAD done flag wait ran out");
        num_errors++;
        conclude();
    endtask
    task automatic slots(input logic [31:0] e);
        for (int k = 0; k < 4; k++) begin
            rc(3'(OFS_RES1 + k), e[8*k +: 8], "result slot");
        end
    endtask
    task automatic stop_exit();
        stop_mode <= 1'h1;
        repeat (5) @(posedge mclk);
        chk8("ready in stop", 8'h00, {7'h0, stop_exit_ready});
        stop_mode <= 1'h0;
        t0 = cyc;
        for (int i = 0; i < 5000; i++) begin
            @(posedge mclk);
            #1;
            if (stop_exit_ready === 1'h1) begin
                lat = cyc - t0;
                return;
            end
        end
        $display("BAD stop exit wait ran out");
        num_errors++;
        conclude();
    endtask
    // ----------------------------------------
    // main sequence
    // ----------------------------------------
    initial begin
        repeat (6) @(posedge mclk);
        reset_n <= 1'h1;
        rc(OFS_CTL, CTL_RST, "ctl reset");
        rc(OFS_OPT, OPT_RST, "opt reset");
        wr(OFS_OPT, 8'h80);
        rc(OFS_OPT, 8'h80, "opt first write");
        chk8("power pin", 8'h01, {7'h0, converter_power_on});
        wr(OFS_OPT, 8'h90);
        rc(OFS_OPT, 8'h80, "opt protected bit");
        // bias settling before any result is trusted
        repeat (12500) @(posedge mclk);
        rc(3'h6, 8'h00, "unmapped read");
        foreach (rows[i]) begin
            start(rows[i].ctl);
            seq_done();
            chk_rng("sequence cycles", 124, 136, lat);
            slots(rows[i].res);
            rc(OFS_CTL, {2'h2, rows[i].ctl[5:0]}, "ctl done");
        end
        wr(OFS_RES1, 8'h5a);
        rc(OFS_RES1, 8'h99, "slot write ignored");
        wr(OFS_CTL, 8'hff);
        rc(OFS_CTL, 8'h3f, "ctl fixed bits");
        start(8'h01);
        repeat (60) @(posedge mclk);
        start(8'h07);
        rc(OFS_CTL, 8'h07, "done cleared");
        seq_done();
        chk_rng("restart cycles", 124, 136, lat);
        slots(32'h88888888);
        start(8'h02);
        repeat (40) @(posedge mclk);
        wait_mode <= 1'h1;
        core.level[2] <= 8'h9c;
        repeat (30) @(posedge mclk);
        chk8("gate in wait", 8'h00, {7'h0, sample_gate});
        wait_mode <= 1'h0;
        @(posedge mclk);
        #1;
        chk8("gate resample", 8'h01, {7'h0, sample_gate});
        seq_done();
        chk_rng("suspended cycles", 150, 200, lat);
        slots(32'h9c9c9c33);
        start(8'h26);
        seq_done();
        core.level[6] <= 8'h42;
        repeat (170) @(posedge mclk);
        slots(32'h42424242);
        rc(OFS_CTL, 8'ha6, "scan done kept");
        // rc clock picked as advised for slow system clocks
        wr(OFS_OPT, 8'hc0);
        rc(OFS_OPT, 8'hc0, "opt clock select");
        chk8("conversion_clock_select pin", 8'h01, {7'h0, conversion_clock_select});
        start(8'h05);
        seq_done();
        chk_rng("rc cycles", 370, 420, lat);
        slots(32'h66666666);
        wr(OFS_OPT, 8'h80);
        // no result trusted after a fast exit, settling outlasts the run
        stop_exit();
        chk_rng("short exit", 1, 6, lat);
        special_mode <= 1'h1;
        wr(OFS_OPT, 8'h90);
        rc(OFS_OPT, 8'h90, "opt special write");
        stop_exit();
        chk_rng("long exit", 3990, 4010, lat);
        conclude();
    end
endmodule
